// >>> hw/logic_slice.sv
// Logic slice: two lookup tables, two wide muxes and two storage elements.
`timescale 1ns/1ns
// Functional notes
// - Each of two tables maps four inputs to one output, any function.
// - Lower wide mux picks between the two table outputs of this slice.
// - Upper wide mux picks between two wide-mux results fed in from outside.
// - Each storage element works as an edge flip-flop or a transparent latch.
// - Each element's data is its combinational output or its bypass input.
// - Flop captures on rising edge with enable high and no force; else holds.
// - Latch follows data while gate and gate enable high; holds otherwise.
// - Synchronous force-high sets a flop at the edge, a latch at once.
// - Synchronous force-low beats synchronous force-high.
// - Asynchronous force-low beats asynchronous force-high.
// - Clock, enable and forces are shared by both elements.
// - Set/reset drives high with the high attribute, low with the low one.
// - Set/reset timing is sync or async per slice; reverse follows it.
// - Reverse, from the upper bypass, drives the opposite state; reset wins.
// - Elements initialise at power-up, configuration, global init, set/reset, reverse.
// - Global init is active high, invertible; loads separate initial values.
// - By default the initial value follows the set/reset attribute choice.
// - Every element control has selectable polarity; active high by default.
// - Clock, enable, set/reset and both bypass inputs have selectable polarity.
module logic_slice
	import slice_pkg::*;
#(
	parameter int TABLE_INPUTS = LUT_INPUTS,
	parameter int TABLE_SIZE   = LUT_SIZE
) (
	// Clock and reset
	input  wire logic                    mclk_in,
	input  wire logic                    resetn_in,
	// Lookup table inputs and contents
	input  wire logic [TABLE_INPUTS-1:0] lower_table_inputs_in,
	input  wire logic [TABLE_INPUTS-1:0] upper_table_inputs_in,
	input  wire logic [TABLE_SIZE-1:0]   lower_table_init_in,
	input  wire logic [TABLE_SIZE-1:0]   upper_table_init_in,
	// Bypass and wide-function inputs
	input  wire logic                    lower_bypass_input_in,
	input  wire logic                    upper_bypass_input_in,
	input  wire logic                    upper_wide_a_in,
	input  wire logic                    upper_wide_b_in,
	// Shared storage controls
	input  wire logic                    slice_clock_in,
	input  wire logic                    clock_enable_in,
	input  wire logic                    set_reset_input_in,
	input  wire logic                    global_init_in,
	// Control polarity, high inverts
	input  wire logic                    invert_clock_in,
	input  wire logic                    invert_enable_in,
	input  wire logic                    invert_set_reset_in,
	input  wire logic                    invert_lower_bypass_in,
	input  wire logic                    invert_upper_bypass_in,
	input  wire logic                    invert_global_init_in,
	// Slice configuration
	input  wire logic                    latch_mode_in,
	input  wire logic                    sr_async_in,
	input  wire logic                    reverse_enable_in,
	input  wire logic                    lower_data_from_bypass_in,
	input  wire logic                    upper_data_from_bypass_in,
	input  wire logic                    lower_init_high_attr_in,
	input  wire logic                    upper_init_high_attr_in,
	input  wire logic                    init_override_in,
	input  wire logic                    lower_powerup_high_value_in,
	input  wire logic                    upper_powerup_high_value_in,
	// Slice outputs
	output logic                         lower_comb_out,
	output logic                         upper_comb_out,
	output logic                         lower_wide_mux_out,
	output logic                         upper_wide_mux_out,
	output logic                         lower_q_out,
	output logic                         upper_q_out
);

	typedef struct packed {
		logic clk_prev;
		logic lower_comb;
		logic upper_comb;
		logic lower_wide;
		logic upper_wide;
	} slice_state_s;

	slice_state_s state_q;
	slice_state_s state_d;
	slice_ctl_if  ctl ();

	logic clk_lvl;
	logic bx_lvl;
	logic by_lvl;
	logic lower_table_out;
	logic upper_table_out;
	logic lower_elem_d;
	logic upper_elem_d;
	logic lower_pv;
	logic upper_pv;

	// ==========================================================
	// Polarity of control inputs
	always_comb begin
		clk_lvl = slice_clock_in ^ invert_clock_in;
		bx_lvl  = lower_bypass_input_in ^ invert_lower_bypass_in;
		by_lvl  = upper_bypass_input_in ^ invert_upper_bypass_in;
	end

	// ==========================================================
	// Shared controls for both elements
	always_comb begin
		ctl.clk_rise    = clk_lvl & ~state_q.clk_prev;
		ctl.gate        = clk_lvl;
		ctl.enable      = clock_enable_in ^ invert_enable_in;
		ctl.set_reset   = set_reset_input_in ^ invert_set_reset_in;
		ctl.reverse     = reverse_enable_in & by_lvl;
		ctl.global_init = global_init_in ^ invert_global_init_in;
		ctl.mode        = latch_mode_in ? MODE_LATCH : MODE_FLOP;
		ctl.sr_timing   = sr_async_in ? SR_ASYNC : SR_SYNC;
	end

	// ==========================================================
	// Lookup tables and data selectors
	always_comb begin
		lower_table_out = lower_table_init_in[lower_table_inputs_in];
		upper_table_out = upper_table_init_in[upper_table_inputs_in];
		lower_elem_d    = lower_data_from_bypass_in ? bx_lvl : lower_table_out;
		upper_elem_d    = upper_data_from_bypass_in ? by_lvl : upper_table_out;
		// Unless overridden, the initial value tracks the set/reset attribute.
		lower_pv        = init_override_in ? lower_powerup_high_value_in : lower_init_high_attr_in;
		upper_pv        = init_override_in ? upper_powerup_high_value_in : upper_init_high_attr_in;
	end

	// ==========================================================
	// Next state of the slice registers
	always_comb begin
		state_d            = state_q;
		state_d.clk_prev   = clk_lvl;
		state_d.lower_comb = lower_table_out;
		state_d.upper_comb = upper_table_out;
		// Bypass high picks the lower table, low the upper one.
		state_d.lower_wide = bx_lvl ? lower_table_out : upper_table_out;
		// Upper bypass high picks feed A, low picks feed B.
		state_d.upper_wide = by_lvl ? upper_wide_a_in : upper_wide_b_in;
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			state_q.clk_prev   <= CLK_PREV_RST;
			state_q.lower_comb <= COMB_RST;
			state_q.upper_comb <= COMB_RST;
			state_q.lower_wide <= COMB_RST;
			state_q.upper_wide <= COMB_RST;
		end else begin
			state_q <= state_d;
		end
	end

	assign lower_comb_out     = state_q.lower_comb;
	assign upper_comb_out     = state_q.upper_comb;
	assign lower_wide_mux_out = state_q.lower_wide;
	assign upper_wide_mux_out = state_q.upper_wide;

	// ==========================================================
	// Storage elements
	storage_element lower_storage_element (
		.mclk_in           (mclk_in),
		.resetn_in         (resetn_in),
		.ctl               (ctl),
		.d_in              (lower_elem_d),
		.init_high_attr_in (lower_init_high_attr_in),
		.powerup_value_in  (lower_pv),
		.q_out             (lower_q_out)
	);

	storage_element upper_storage_element (
		.mclk_in           (mclk_in),
		.resetn_in         (resetn_in),
		.ctl               (ctl),
		.d_in              (upper_elem_d),
		.init_high_attr_in (upper_init_high_attr_in),
		.powerup_value_in  (upper_pv),
		.q_out             (upper_q_out)
	);

	// ==========================================================
	// Checks
	a_lower_table: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		1'b1 |=> (lower_comb_out == $past(lower_table_init_in[lower_table_inputs_in])))
		else $error("lower table output wrong");
	a_upper_table: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		1'b1 |=> (upper_comb_out == $past(upper_table_init_in[upper_table_inputs_in])))
		else $error("upper table output wrong");
	a_lower_wide: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(bx_lvl == 1'b0) |=> (lower_wide_mux_out == $past(upper_table_out)))
		else $error("lower wide mux picked the wrong table");
	a_upper_wide: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(by_lvl == 1'b1) |=> (upper_wide_mux_out == $past(upper_wide_a_in)))
		else $error("upper wide mux picked the wrong feed");
	a_shared_edge: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_FLOP && ctl.clk_rise && ctl.enable && !ctl.global_init
			&& !ctl.set_reset && !ctl.reverse && lower_data_from_bypass_in
			&& upper_data_from_bypass_in && reverse_enable_in == 1'b0)
			|=> (lower_q_out == $past(bx_lvl)) && (upper_q_out == $past(by_lvl)))
		else $error("elements did not capture on the shared edge");
	a_sync_edge: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_FLOP && ctl.sr_timing == SR_SYNC && ctl.clk_rise
			&& ctl.set_reset && !ctl.reverse && !ctl.global_init)
			|=> (lower_q_out == $past(lower_init_high_attr_in)))
		else $error("synchronous set/reset missed the edge");

	// ==========================================================
	// Checks of the wide muxes and the initial values
	a_lower_wide_high: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(bx_lvl == 1'h1) |=> (lower_wide_mux_out == $past(lower_table_out)))
		else $error("lower wide mux missed the lower table");

	a_upper_wide_low: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(by_lvl == 1'h0) |=> (upper_wide_mux_out == $past(upper_wide_b_in)))
		else $error("upper wide mux missed feed B");

	// Without the override each initial value follows its set/reset attribute.
	a_lower_init_attr: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.global_init && !init_override_in)
			|=> (lower_q_out == $past(lower_init_high_attr_in)))
		else $error("lower initial value ignored its attribute");

	a_upper_init_attr: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.global_init && !init_override_in)
			|=> (upper_q_out == $past(upper_init_high_attr_in)))
		else $error("upper initial value ignored its attribute");

	// With the override the separate initial-value inputs take over.
	a_lower_init_over: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.global_init && init_override_in)
			|=> (lower_q_out == $past(lower_powerup_high_value_in)))
		else $error("lower override initial value not loaded");

	a_upper_init_over: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.global_init && init_override_in)
			|=> (upper_q_out == $past(upper_powerup_high_value_in)))
		else $error("upper override initial value not loaded");

	// An inverted global init that is held high must leave both elements alone.
	a_init_inverted: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(global_init_in && invert_global_init_in && ctl.mode == MODE_FLOP
			&& ctl.sr_timing == SR_SYNC && !ctl.clk_rise)
			|=> ($stable(lower_q_out) && $stable(upper_q_out)))
		else $error("inverted global init still loaded a value");

	// ==========================================================
	// Checks of the forces, data captures and holds on both elements
	a_upper_sync_edge: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_FLOP && ctl.sr_timing == SR_SYNC && ctl.clk_rise
			&& ctl.set_reset && !ctl.reverse && !ctl.global_init)
			|=> (upper_q_out == $past(upper_init_high_attr_in)))
		else $error("upper synchronous set/reset missed the edge");

	// Set/reset and reverse together always leave the low state.
	a_sync_both_low: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_FLOP && ctl.sr_timing == SR_SYNC && ctl.clk_rise
			&& ctl.set_reset && ctl.reverse && !ctl.global_init)
			|=> (!lower_q_out && !upper_q_out))
		else $error("synchronous force-low did not win");

	a_async_both_low: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.sr_timing == SR_ASYNC && ctl.set_reset && ctl.reverse && !ctl.global_init)
			|=> (!lower_q_out && !upper_q_out))
		else $error("asynchronous force-low did not win");

	a_async_pair_set: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.sr_timing == SR_ASYNC && ctl.set_reset && !ctl.reverse && !ctl.global_init)
			|=> (lower_q_out == $past(lower_init_high_attr_in))
			&& (upper_q_out == $past(upper_init_high_attr_in)))
		else $error("asynchronous set/reset gave the wrong states");

	a_reverse_opposite: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.sr_timing == SR_ASYNC && ctl.reverse && !ctl.set_reset && !ctl.global_init)
			|=> (lower_q_out != $past(lower_init_high_attr_in))
			&& (upper_q_out != $past(upper_init_high_attr_in)))
		else $error("reverse did not give the opposite states");

	// A latch takes a force at once, with no slice clock edge.
	a_latch_set_now: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_LATCH && ctl.set_reset && !ctl.reverse && !ctl.global_init)
			|=> (lower_q_out == $past(lower_init_high_attr_in))
			&& (upper_q_out == $past(upper_init_high_attr_in)))
		else $error("latch force did not act at once");

	a_latch_lower_data: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_LATCH && ctl.gate && ctl.enable && !ctl.set_reset && !ctl.reverse
			&& !ctl.global_init && lower_data_from_bypass_in) |=> (lower_q_out == $past(bx_lvl)))
		else $error("open lower latch did not follow its bypass");

	a_flop_upper_table: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_FLOP && ctl.clk_rise && ctl.enable && !ctl.set_reset && !ctl.reverse
			&& !ctl.global_init && !upper_data_from_bypass_in)
			|=> (upper_q_out == $past(upper_table_out)))
		else $error("upper flop did not capture its table output");

	// Both elements hold together, since they share one enable and one gate.
	a_flop_pair_hold: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_FLOP && !ctl.enable && !ctl.set_reset && !ctl.reverse && !ctl.global_init)
			|=> ($stable(lower_q_out) && $stable(upper_q_out)))
		else $error("a flop changed with the shared enable low");

	a_latch_pair_hold: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_LATCH && !(ctl.gate && ctl.enable) && !ctl.set_reset && !ctl.reverse
			&& !ctl.global_init) |=> ($stable(lower_q_out) && $stable(upper_q_out)))
		else $error("a closed latch changed");

endmodule

// >>> common/slice_pkg.sv
// Shared constants and types for the logic slice model.
package slice_pkg;

	// ==========================================================
	// Lookup table geometry
	localparam int   LUT_INPUTS   = 4;
	localparam int   LUT_SIZE     = 16;

	// ==========================================================
	// Reset values of the slice state
	localparam logic CLK_PREV_RST = 1'h0;
	localparam logic COMB_RST     = 1'h0;
	localparam logic ELEM_RST     = 1'h0;

	// ==========================================================
	// Storage element operating modes
	typedef enum logic [0:0] {
		MODE_FLOP  = 1'b0,
		MODE_LATCH = 1'b1
	} storage_mode_e;

	typedef enum logic [0:0] {
		SR_SYNC  = 1'b0,
		SR_ASYNC = 1'b1
	} sr_timing_e;

endpackage

// >>> common/slice_ctl_if.sv
// Shared control bundle from the slice to its two storage elements.
`timescale 1ns/1ns
interface slice_ctl_if;
	import slice_pkg::*;
	logic          clk_rise;
	logic          gate;
	logic          enable;
	logic          set_reset;
	logic          reverse;
	logic          global_init;
	storage_mode_e mode;
	sr_timing_e    sr_timing;

	modport drive (
		output clk_rise, gate, enable, set_reset, reverse, global_init, mode, sr_timing
	);
	modport take (
		input  clk_rise, gate, enable, set_reset, reverse, global_init, mode, sr_timing
	);
endinterface

// >>> hw/storage_element.sv
// One slice storage element: flip-flop or transparent latch with forces.
`timescale 1ns/1ns
module storage_element
	import slice_pkg::*;
(
	// Clock and reset
	input  wire logic  mclk_in,
	input  wire logic  resetn_in,
	// Shared slice controls
	slice_ctl_if.take  ctl,
	// Per-element data and attributes
	input  wire logic  d_in,
	input  wire logic  init_high_attr_in,
	input  wire logic  powerup_value_in,
	output logic       q_out
);

	typedef struct packed {
		logic q;
	} elem_state_s;

	elem_state_s state_q;
	elem_state_s state_d;
	logic        force_low;
	logic        force_high;
	logic        force_now;

	// ==========================================================
	// Next state
	always_comb begin
		state_d    = state_q;
		// Set/reset drives the attribute state, reverse the opposite one.
		force_low  = (ctl.set_reset & ~init_high_attr_in) | (ctl.reverse & init_high_attr_in);
		force_high = (ctl.set_reset & init_high_attr_in) | (ctl.reverse & ~init_high_attr_in);
		// Forces act at once when asynchronous or in latch mode, else on the edge.
		force_now  = (ctl.sr_timing == SR_ASYNC) || (ctl.mode == MODE_LATCH) || ctl.clk_rise;
		if (ctl.global_init) begin
			state_d.q = powerup_value_in;
		end else if (force_now && force_low) begin
			state_d.q = 1'b0;
		end else if (force_now && force_high) begin
			state_d.q = 1'b1;
		end else begin
			case (ctl.mode)
				MODE_FLOP: begin
					if (ctl.clk_rise && ctl.enable) begin
						state_d.q = d_in;
					end
				end
				MODE_LATCH: begin
					if (ctl.gate && ctl.enable) begin
						state_d.q = d_in;
					end
				end
				default: begin
					state_d.q = state_q.q;
				end
			endcase
		end
	end

	// ==========================================================
	// State register; reset stands for power-up and configuration.
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			state_q.q <= ELEM_RST;
		end else begin
			state_q <= state_d;
		end
	end

	assign q_out = state_q.q;

	// ==========================================================
	// Checks
	a_ff_capture: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_FLOP && ctl.clk_rise && ctl.enable && !ctl.global_init
			&& !ctl.set_reset && !ctl.reverse) |=> (q_out == $past(d_in)))
		else $error("flop did not capture data");
	a_ff_hold: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_FLOP && !ctl.enable && !ctl.global_init
			&& !ctl.set_reset && !ctl.reverse) |=> $stable(q_out))
		else $error("flop changed with enable low");
	a_latch_follow: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_LATCH && ctl.gate && ctl.enable && !ctl.global_init
			&& !ctl.set_reset && !ctl.reverse) |=> (q_out == $past(d_in)))
		else $error("open latch did not follow data");
	a_latch_hold: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_LATCH && !(ctl.gate && ctl.enable) && !ctl.global_init
			&& !ctl.set_reset && !ctl.reverse) |=> $stable(q_out))
		else $error("closed latch changed");
	a_sync_wait: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.mode == MODE_FLOP && ctl.sr_timing == SR_SYNC && !ctl.clk_rise
			&& !ctl.global_init) |=> $stable(q_out))
		else $error("synchronous flop changed without an edge");
	a_force_low_wins: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.set_reset && ctl.reverse && ctl.sr_timing == SR_ASYNC && !ctl.global_init)
			|=> !q_out)
		else $error("reset condition did not win");
	a_sr_state: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		(ctl.set_reset && !ctl.reverse && ctl.sr_timing == SR_ASYNC && !ctl.global_init)
			|=> (q_out == $past(init_high_attr_in)))
		else $error("set/reset gave the wrong state");
	a_global_init: assert property (@(posedge mclk_in) disable iff (!resetn_in)
		ctl.global_init |=> (q_out == $past(powerup_value_in)))
		else $error("global init did not load the initial value");

endmodule

// >>> tb/fabric_model.sv
// Interconnect model that drives the slice clock or latch gate for the bench.
`timescale 1ns/1ns
module fabric_model (
	// Clock
	input  wire logic mclk_in,
	// Gate request from the bench
	input  wire logic gate_req_in,
	// Routed slice clock or gate
	output logic      slice_clock_out
);
	// ==========================================================
	// Routing register
	// The fabric registers the request, so the slice sees a clean level one cycle later.
	always_ff @(posedge mclk_in) begin
		slice_clock_out <= gate_req_in;
	end
endmodule

// >>> tb/logic_slice_test.sv
// Self-checking bench for the logic slice, clocked through the fabric model.
`timescale 1ns/1ns
module logic_slice_test;
	logic        mclk_in, resetn_in, gate_req, slice_clock_in;
	logic [3:0]  lower_table_inputs_in, upper_table_inputs_in;
	logic [15:0] lower_table_init_in, upper_table_init_in;
	logic        lower_bypass_input_in, upper_bypass_input_in, upper_wide_a_in, upper_wide_b_in;
	logic        clock_enable_in, set_reset_input_in, global_init_in, latch_mode_in, sr_async_in;
	logic        invert_clock_in, invert_enable_in, invert_set_reset_in, invert_global_init_in;
	logic        invert_lower_bypass_in, invert_upper_bypass_in, reverse_enable_in, init_override_in;
	logic        lower_data_from_bypass_in, upper_data_from_bypass_in;
	logic        lower_init_high_attr_in, upper_init_high_attr_in;
	logic        lower_powerup_high_value_in, upper_powerup_high_value_in;
	logic        lower_comb_out, upper_comb_out, lower_wide_mux_out, upper_wide_mux_out;
	logic        lower_q_out, upper_q_out;
	logic [15:0] lo_t, up_t;
	int          err_total = 0;
	int          comparisons = 0;

	logic_slice logic_slice_i (
		.mclk_in, .resetn_in, .lower_table_inputs_in, .upper_table_inputs_in,
		.lower_table_init_in, .upper_table_init_in, .lower_bypass_input_in, .upper_bypass_input_in,
		.upper_wide_a_in, .upper_wide_b_in, .slice_clock_in, .clock_enable_in, .set_reset_input_in,
		.global_init_in, .invert_clock_in, .invert_enable_in, .invert_set_reset_in,
		.invert_lower_bypass_in, .invert_upper_bypass_in, .invert_global_init_in, .latch_mode_in,
		.sr_async_in, .reverse_enable_in, .lower_data_from_bypass_in, .upper_data_from_bypass_in,
		.lower_init_high_attr_in, .upper_init_high_attr_in, .init_override_in,
		.lower_powerup_high_value_in, .upper_powerup_high_value_in, .lower_comb_out,
		.upper_comb_out, .lower_wide_mux_out, .upper_wide_mux_out, .lower_q_out, .upper_q_out
	);

	fabric_model fabric_model_i (.mclk_in, .gate_req_in(gate_req), .slice_clock_out(slice_clock_in));

	// ==========================================================
	// Clock, access tasks and verdict
	initial mclk_in = 1'h0;
	always #4 mclk_in = ~mclk_in;

	task automatic step(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	task automatic check(input logic got, input logic exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t %s got %b want %b", $time, what, got, exp);
		end
	endtask

	task automatic qs(input logic lo, input logic up);
		check(lower_q_out, lo, "lower q");
		check(upper_q_out, up, "upper q");
	endtask

	// One slice clock pulse; both edges have landed in the elements when it returns.
	task automatic pulse();
		gate_req = 1'h1;
		step(1);
		gate_req = 1'h0;
		step(3);
	endtask

	task automatic init_pulse(input logic active);
		global_init_in = active;
		step(1);
		global_init_in = ~active;
		step(1);
	endtask

	task automatic done(input string name);
		$display("test %s done", name);
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (100000) @(posedge mclk_in);
		err_total++;
		$display("ERROR t=%0t run limit reached", $time);
		end_sim();
	end

	// ==========================================================
	// Main sequence
	initial begin
		{lower_table_inputs_in, upper_table_inputs_in, lower_table_init_in, upper_table_init_in} = '0;
		{lower_bypass_input_in, upper_bypass_input_in, upper_wide_a_in, upper_wide_b_in, gate_req} = '0;
		{clock_enable_in, set_reset_input_in, global_init_in, latch_mode_in, sr_async_in} = '0;
		{invert_clock_in, invert_enable_in, invert_set_reset_in, invert_global_init_in} = '0;
		{invert_lower_bypass_in, invert_upper_bypass_in, reverse_enable_in, init_override_in} = '0;
		{lower_data_from_bypass_in, upper_data_from_bypass_in, lower_init_high_attr_in} = '0;
		{upper_init_high_attr_in, lower_powerup_high_value_in, upper_powerup_high_value_in} = '0;
		resetn_in = 1'h0;
		step(10);
		qs(1'h0, 1'h0);
		resetn_in = 1'h1;
		step(1);
		lower_init_high_attr_in = 1'h1;
		init_pulse(1'h1);
		qs(1'h1, 1'h0);
		{init_override_in, lower_powerup_high_value_in, upper_powerup_high_value_in} = 3'h5;
		init_pulse(1'h1);
		qs(1'h0, 1'h1);
		{init_override_in, invert_global_init_in, global_init_in} = 3'h3;
		step(2);
		qs(1'h0, 1'h1);
		init_pulse(1'h0);
		qs(1'h1, 1'h0);
		{invert_global_init_in, global_init_in} = 2'h0;
		done("init");

		for (int k = 0; k < 2; k++) begin
			lo_t = (k == 0) ? 16'h6996 : 16'h8001;
			up_t = (k == 0) ? 16'hf00d : 16'h7ffe;
			lower_table_init_in = lo_t;
			upper_table_init_in = up_t;
			for (int i = 0; i < 16; i++) begin
				lower_table_inputs_in = i[3:0];
				upper_table_inputs_in = 4'hf - i[3:0];
				{upper_wide_a_in, upper_bypass_input_in, lower_bypass_input_in} = i[2:0];
				upper_wide_b_in = ~i[2];
				step(1);
				check(lower_comb_out, lo_t[i], "lower table");
				check(upper_comb_out, up_t[15-i], "upper table");
				check(lower_wide_mux_out, i[0] ? lo_t[i] : up_t[15-i], "lower wide");
				check(upper_wide_mux_out, i[1] ? i[2] : ~i[2], "upper wide");
			end
		end
		qs(1'h1, 1'h0);
		done("tables");

		{lower_data_from_bypass_in, lower_bypass_input_in, clock_enable_in} = 3'h5;
		upper_table_init_in = 16'hffff;
		pulse();
		qs(1'h0, 1'h1);
		{lower_bypass_input_in, clock_enable_in} = 2'h2;
		upper_table_init_in = 16'h0000;
		pulse();
		qs(1'h0, 1'h1);
		clock_enable_in = 1'h1;
		step(3);
		qs(1'h0, 1'h1);
		upper_data_from_bypass_in = 1'h1;
		pulse();
		qs(1'h1, 1'h1);
		upper_data_from_bypass_in = 1'h0;
		pulse();
		qs(1'h1, 1'h0);
		done("flop");

		{clock_enable_in, lower_bypass_input_in, upper_init_high_attr_in, lower_init_high_attr_in} = 4'h2;
		set_reset_input_in = 1'h1;
		step(3);
		qs(1'h1, 1'h0);
		pulse();
		qs(1'h0, 1'h1);
		{reverse_enable_in, upper_bypass_input_in} = 2'h3;
		pulse();
		qs(1'h0, 1'h0);
		set_reset_input_in = 1'h0;
		pulse();
		qs(1'h1, 1'h0);
		{sr_async_in, reverse_enable_in, set_reset_input_in} = 3'h5;
		step(2);
		qs(1'h0, 1'h1);
		reverse_enable_in = 1'h1;
		step(2);
		qs(1'h0, 1'h0);
		set_reset_input_in = 1'h0;
		step(2);
		qs(1'h1, 1'h0);
		{sr_async_in, reverse_enable_in, upper_bypass_input_in} = 3'h0;
		done("forces");

		{latch_mode_in, clock_enable_in, gate_req} = 3'h7;
		step(2);
		qs(1'h0, 1'h0);
		lower_bypass_input_in = 1'h1;
		step(2);
		qs(1'h1, 1'h0);
		gate_req = 1'h0;
		step(2);
		lower_bypass_input_in = 1'h0;
		step(2);
		qs(1'h1, 1'h0);
		set_reset_input_in = 1'h1;
		step(2);
		qs(1'h0, 1'h1);
		{latch_mode_in, set_reset_input_in, clock_enable_in} = 3'h0;
		done("latch");

		invert_clock_in = 1'h1;
		step(3);
		{invert_enable_in, invert_lower_bypass_in, invert_upper_bypass_in, upper_wide_a_in} = 4'hf;
		{lower_table_init_in, upper_table_init_in, upper_wide_b_in} = {16'h0000, 16'hffff, 1'h0};
		step(3);
		qs(1'h0, 1'h1);
		check(lower_wide_mux_out, 1'h0, "lower wide inverted");
		check(upper_wide_mux_out, 1'h1, "upper wide inverted");
		pulse();
		qs(1'h1, 1'h1);
		{invert_set_reset_in, set_reset_input_in, lower_init_high_attr_in} = 3'h6;
		step(2);
		set_reset_input_in = 1'h0;
		pulse();
		qs(1'h0, 1'h1);
		done("polarity");
		end_sim();
	end
endmodule
